// ---- src/ach_defs.vh ----
// Constants for the angle commutation, hysteresis and turns block
`ifndef ACH_DEFS_VH
`define ACH_DEFS_VH
`define ACH_ANG_W 14
`define ACH_HYS_W 6
`define ACH_PP_W 4
`define ACH_TURN_W 12
`define ACH_READBACK_W 12
`define ACH_REG_W 16
`define ACH_ADDR_W 8
`define ACH_ADDR_CTRL 8'h1e
`define ACH_ADDR_WARN 8'h26
`define ACH_ADDR_HANG 8'h22
`define ACH_ADDR_STAT 8'h24
`define ACH_CTRL_CMD_LSB 0
`define ACH_CTRL_CMD_W 4
`define ACH_CMD_TURN_RESET 4'h5
`define ACH_WARN_TURN_BIT 0
`define ACH_STAT_ROT_BIT 0
`define ACH_FULL_CYCLE 18'h30000
`define ACH_THIRD_CYCLE 18'h10000
`define ACH_TWO_THIRD 18'h20000
`define ACH_HALF_CYCLE 18'h18000
`define ACH_T45_MAX 12'h7ff
`define ACH_T45_MIN 12'h800
`define ACH_T180_MAX 12'h1ff
`define ACH_T180_MIN 12'he00
`define ACH_OCT_W 3
`define ACH_ZERO14 14'h0000
`define ACH_ZERO12 12'h000
`define ACH_ZERO16 16'h0000
`endif

// ---- src/ach_hysteresis.v ----
// Direction-aware hysteresis window applied to the sensor angle
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.vh"
module ach_hysteresis (
	input wire mclk, // Core clock
	input wire reset_n, // Async reset, active low
	input wire self_test_done, // Restart after logic self-test
	input wire [`ACH_ANG_W-1:0] sensor_angle, // Compensated sensor angle
	input wire [`ACH_HYS_W-1:0] angle_window_width, // Window width in 14-bit steps
	output reg [`ACH_ANG_W-1:0] filtered_angle, // Hysteresis output angle
	output reg reference_direction_flag // 0 increasing, 1 decreasing
);
	reg primed;
	wire [`ACH_ANG_W-1:0] delta;
	wire [`ACH_ANG_W-1:0] back;
	assign delta = sensor_angle - filtered_angle;
	assign back = filtered_angle - sensor_angle;

	// Head follows sensor in reference direction; opposite moves held inside window
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			filtered_angle <= `ACH_ZERO14;
			reference_direction_flag <= 1'b0;
			primed <= 1'b0;
		end else if (self_test_done || !primed) begin
			// Window trails the initial angle, direction increasing
			filtered_angle <= sensor_angle;
			reference_direction_flag <= 1'b0;
			primed <= 1'b1;
		end else if (!reference_direction_flag) begin
			if (!delta[`ACH_ANG_W-1]) begin
				filtered_angle <= sensor_angle;
			end else if (back > {8'h00, angle_window_width}) begin
				filtered_angle <= sensor_angle;
				reference_direction_flag <= 1'b1;
			end
			// Otherwise held inside the window
		end else begin
			if (!back[`ACH_ANG_W-1]) begin
				filtered_angle <= sensor_angle;
			end else if (delta > {8'h00, angle_window_width}) begin
				filtered_angle <= sensor_angle;
				reference_direction_flag <= 1'b0;
			end
		end
	end
endmodule // ach_hysteresis
`default_nettype wire

// ---- src/ach_turns.v ----
// Saturating signed turns counter fed by the low-power track path
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.vh"
module ach_turns (
	input wire mclk, // Core clock
	input wire reset_n, // Async reset, active low
	input wire [`ACH_OCT_W-1:0] low_power_track_path, // Coarse octant of rotation
	input wire turn_step_select, // 1 = 45 degree steps, 0 = 180 degree
	input wire turn_reset, // One-cycle counter reset command
	output reg [`ACH_TURN_W-1:0] turn_count, // Signed turns count
	output reg turn_warning // Saturation warning, sticky
);
	reg [`ACH_OCT_W-1:0] last_oct;
	reg [`ACH_OCT_W-1:0] base_oct;
	wire [`ACH_OCT_W-1:0] step;
	wire [`ACH_OCT_W-1:0] rel_old;
	wire [`ACH_OCT_W-1:0] rel_new;
	wire up;
	wire down;
	wire hit_max;
	wire hit_min;
	assign step = low_power_track_path - last_oct;
	assign rel_old = last_oct - base_oct;
	assign rel_new = low_power_track_path - base_oct;
	// Half-turn crossings happen between relative octants 3/4 and 7/0
	assign up = (step == 3'h1) && (turn_step_select || rel_new == 3'h4 || rel_new == 3'h0);
	assign down = (step == 3'h7) && (turn_step_select || rel_old == 3'h4 || rel_old == 3'h0);
	assign hit_max = turn_step_select ? (turn_count == `ACH_T45_MAX) :
		(turn_count == `ACH_T180_MAX);
	assign hit_min = turn_step_select ? (turn_count == `ACH_T45_MIN) :
		(turn_count == `ACH_T180_MIN);

	// Counting, clamping and the sticky warning
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			turn_count <= `ACH_ZERO12;
			turn_warning <= 1'b0;
			last_oct <= 3'h0;
			base_oct <= 3'h0;
		end else begin
			last_oct <= low_power_track_path;
			if (turn_reset) begin
				turn_count <= `ACH_ZERO12;
				base_oct <= low_power_track_path;
				turn_warning <= 1'b0;
			end else if (up) begin
				if (hit_max) turn_warning <= 1'b1;
				else turn_count <= turn_count + 12'h001;
			end else if (down) begin
				if (hit_min) turn_warning <= 1'b1;
				else turn_count <= turn_count - 12'h001;
			end
		end
	end
endmodule // ach_turns
`default_nettype wire

// ---- src/ach_top.v ----
// Commutation outputs, hysteresis routing, turns counter and serial registers
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.vh"
module ach_top (
	input wire mclk, // Core clock, 20 MHz
	input wire reset_n, // Async reset, active low
	input wire self_test_done, // Pulse after logic self-test
	input wire [`ACH_ANG_W-1:0] sensor_angle, // Compensated 14-bit angle
	input wire [`ACH_OCT_W-1:0] low_power_track_path, // Secondary path octant
	input wire [`ACH_PP_W-1:0] resolution_pairs, // Config word bits 3:0
	input wire filtered_angle_route_enable, // Config word bit 12
	input wire [`ACH_HYS_W-1:0] angle_window_width, // Window width field
	input wire turn_step_select, // 1 = 45 degree turns steps
	input wire reg_wr, // Serial register write strobe
	input wire reg_rd, // Serial register read strobe
	input wire [`ACH_ADDR_W-1:0] reg_addr, // Serial register address
	input wire [`ACH_REG_W-1:0] reg_wdata, // Serial register write data
	output reg [`ACH_REG_W-1:0] reg_rdata, // Registered read data
	output reg phase_u, // Commutation U
	output reg phase_v, // Commutation V
	output reg phase_w, // Commutation W
	output wire [`ACH_ANG_W-1:0] quad_angle, // Angle feeding quadrature logic
	output wire reference_direction_flag, // Hysteresis direction
	output wire [`ACH_TURN_W-1:0] turn_count, // Signed turns count
	output wire turn_warning // Turns saturation warning
);
	reg [`ACH_REG_W-1:0] device_command_control;
	reg turn_reset;
	wire [`ACH_ANG_W-1:0] filtered_angle;
	wire [`ACH_ANG_W-1:0] drive_angle;
	wire [17:0] elec;

	// Electrical position: angle times pole pairs, modulo full electrical cycle
	function [17:0] elec_pos;
		input [`ACH_ANG_W-1:0] ang;
		input [`ACH_PP_W-1:0] pp;
		reg [17:0] prod;
		begin
			prod = ang * ({14'h0000, pp} + 18'h00001);
			// Scale so one electrical cycle spans ACH_FULL_CYCLE (3 * 2^16)
			elec_pos = prod[`ACH_ANG_W-1:0] * 18'h3 * 18'h4;
		end
	endfunction

	// Phase level over a half-cycle window starting at an offset
	function phase_level;
		input [17:0] pos;
		input [17:0] offs;
		reg [17:0] rel;
		begin
			rel = (pos >= offs) ? pos - offs : pos + `ACH_FULL_CYCLE - offs;
			phase_level = (rel < `ACH_HALF_CYCLE);
		end
	endfunction

	ach_hysteresis u_hys (
		.mclk(mclk),
		.reset_n(reset_n),
		.self_test_done(self_test_done),
		.sensor_angle(sensor_angle),
		.angle_window_width(angle_window_width),
		.filtered_angle(filtered_angle),
		.reference_direction_flag(reference_direction_flag)
	);

	ach_turns u_turns (
		.mclk(mclk),
		.reset_n(reset_n),
		.low_power_track_path(low_power_track_path),
		.turn_step_select(turn_step_select),
		.turn_reset(turn_reset),
		.turn_count(turn_count),
		.turn_warning(turn_warning)
	);

	// Choose the angle that drives the commutation and quadrature outputs
	assign drive_angle = filtered_angle_route_enable ? filtered_angle : sensor_angle;
	assign quad_angle = drive_angle;
	assign elec = elec_pos(drive_angle, resolution_pairs);

	// Phases are registered: each flips on the clock after the electrical position crosses its edge
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_u <= 1'b0;
			phase_v <= 1'b0;
			phase_w <= 1'b0;
		end else begin
			phase_u <= phase_level(elec, 18'h00000);
			phase_v <= phase_level(elec, `ACH_THIRD_CYCLE);
			phase_w <= phase_level(elec, `ACH_TWO_THIRD);
		end
	end

	// Control register; the reset command is a one-cycle pulse into the counter
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			device_command_control <= `ACH_ZERO16;
			turn_reset <= 1'b0;
		end else begin
			turn_reset <= 1'b0;
			if (reg_wr && reg_addr == `ACH_ADDR_CTRL) begin
				device_command_control <= reg_wdata;
				if (reg_wdata[`ACH_CTRL_CMD_LSB +: `ACH_CTRL_CMD_W] == `ACH_CMD_TURN_RESET)
					turn_reset <= 1'b1;
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= `ACH_ZERO16;
		end else if (reg_rd) begin
			if (reg_addr == `ACH_ADDR_CTRL) begin
				reg_rdata <= device_command_control;
			end else if (reg_addr == `ACH_ADDR_WARN) begin
				reg_rdata <= {15'h0000, turn_warning};
			end else if (reg_addr == `ACH_ADDR_HANG) begin
				reg_rdata <= {4'h0, filtered_angle[`ACH_ANG_W-1:2]};
			end else if (reg_addr == `ACH_ADDR_STAT) begin
				reg_rdata <= {15'h0000, reference_direction_flag};
			end else begin
				reg_rdata <= `ACH_ZERO16;
			end
		end
	end
endmodule // ach_top
`default_nettype wire

// ---- testbench/ach_top_asserts.sv ----
// Port-level checker for the commutation, hysteresis and turns block
`timescale 1ns/1ps
`default_nettype none
`include "ach_defs.vh"
module ach_top_asserts (
	input wire logic mclk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic [`ACH_ANG_W-1:0] sensor_angle, // Raw angle
	input wire logic [`ACH_PP_W-1:0] resolution_pairs, // Pole pairs - 1
	input wire logic filtered_angle_route_enable, // Route select
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [`ACH_ADDR_W-1:0] reg_addr, // Address
	input wire logic [`ACH_REG_W-1:0] reg_wdata, // Write data
	input wire logic [`ACH_REG_W-1:0] reg_rdata, // Read data
	input wire logic phase_u, // Phase U
	input wire logic phase_v, // Phase V
	input wire logic phase_w, // Phase W
	input wire logic [`ACH_ANG_W-1:0] quad_angle, // Selected angle
	input wire logic reference_direction_flag, // Direction
	input wire logic [`ACH_TURN_W-1:0] turn_count, // Turns
	input wire logic turn_warning // Saturation flag
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Turns reset command as it lands on the control register
	wire wr_cmd = reg_wr && reg_addr == `ACH_ADDR_CTRL && reg_wdata[3:0] == `ACH_CMD_TURN_RESET;
	warn_read_a: assert property (reg_rd && reg_addr == `ACH_ADDR_WARN
		|=> reg_rdata == {15'h0000, $past(turn_warning)}) else $error("warning readback wrong");
	dir_read_a: assert property (reg_rd && reg_addr == `ACH_ADDR_STAT
		|=> reg_rdata[0] == $past(reference_direction_flag)) else $error("direction readback wrong");
	// Only while routed does the selected angle show the filtered one
	hang_read_a: assert property (reg_rd && reg_addr == `ACH_ADDR_HANG && filtered_angle_route_enable
		|=> reg_rdata == {4'h0, $past(quad_angle[13:2])}) else $error("filtered readback wrong");
	phase_edge_a: assert property (!filtered_angle_route_enable && resolution_pairs == 4'h0
		|=> phase_u == ($past(sensor_angle) < 14'h2000)) else $error("phase u edge wrong");
	uvw_valid_a: assert property ($past(reset_n)
		|-> !(phase_u == phase_v && phase_v == phase_w)) else $error("phases all equal");
	quad_route_a: assert property (!filtered_angle_route_enable
		|-> quad_angle == sensor_angle) else $error("quad angle not raw");
	turn_step_a: assert property (turn_count != $past(turn_count)
		|-> turn_count == $past(turn_count) + 12'h001 || turn_count == $past(turn_count) - 12'h001
		|| turn_count == 12'h000) else $error("turns jumped");
	warn_rise_a: assert property ($rose(turn_warning)
		|-> turn_count inside {12'h7ff, 12'h800, 12'h1ff, 12'he00}) else $error("warning off limit");
	warn_hold_a: assert property (turn_warning && !wr_cmd && !$past(wr_cmd)
		|=> turn_warning) else $error("warning dropped");
	turn_clear_a: assert property (wr_cmd
		|-> ##2 turn_count == 12'h000 && !turn_warning) else $error("turns not cleared");
	cover property (wr_cmd);
	cover property ($rose(reference_direction_flag));
	cover property ($rose(turn_warning));
endmodule // ach_top_asserts
bind ach_top ach_top_asserts chk (.mclk, .reset_n, .sensor_angle, .resolution_pairs,
	.filtered_angle_route_enable, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .phase_u,
	.phase_v, .phase_w, .quad_angle, .reference_direction_flag, .turn_count, .turn_warning);
`default_nettype wire

// ---- testbench/ach_motor_model.sv ----
// Motor controller model reading the three phase outputs
`timescale 1ns/1ps
`default_nettype none
module ach_motor_model (
	input wire logic mclk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic phase_u, // Phase U
	input wire logic phase_v, // Phase V
	input wire logic phase_w, // Phase W
	output var int bad // Illegal phase states seen
);
	logic [1:0] arm = 2'h0;
	// A controller cannot commutate on 000 or 111; skip the reset edges
	always @(posedge mclk) begin
		arm <= {arm[0], reset_n};
		if (reset_n && arm[1] && phase_u == phase_v && phase_v == phase_w) bad <= bad + 1;
	end
	initial bad = 0;
endmodule // ach_motor_model
`default_nettype wire

// ---- testbench/ach_top_tb_top.sv ----
// Self-checking bench for the commutation, hysteresis and turns block
`timescale 1ns/1ps
`default_nettype none
module ach_top_tb_top;
	logic mclk = 0, reset_n = 0, self_test_done = 0, route = 0, tss = 1, reg_wr = 0, reg_rd = 0;
	logic [13:0] ang = 0;
	logic [2:0] oct = 0;
	logic [3:0] pp = 0;
	logic [5:0] wid = 0;
	logic [7:0] addr = 0;
	logic [15:0] wd = 0, d;
	wire [15:0] rd;
	wire [13:0] qa;
	wire [11:0] tc;
	wire u, v, w, dir, warn;
	int fails = 0, compares = 0, cyc = 0, bad;
	int tab [8][3] = '{'{995, 1000, 0}, '{990, 1000, 0}, '{989, 989, 1}, '{980, 980, 1},
		'{985, 980, 1}, '{990, 980, 1}, '{991, 991, 0}, '{1200, 1200, 0}};
	ach_top dut (.mclk, .reset_n, .self_test_done, .sensor_angle(ang), .low_power_track_path(oct),
		.resolution_pairs(pp), .filtered_angle_route_enable(route), .angle_window_width(wid),
		.turn_step_select(tss), .reg_wr, .reg_rd, .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rd),
		.phase_u(u), .phase_v(v), .phase_w(w), .quad_angle(qa), .reference_direction_flag(dir),
		.turn_count(tc), .turn_warning(warn));
	ach_motor_model mm (.mclk, .reset_n, .phase_u(u), .phase_v(v), .phase_w(w), .bad(bad));
	initial forever #25 mclk = ~mclk;
	// Whole run needs about 5000 cycles, so 20000 means a hang
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			tally_and_finish;
		end
	end
	task step(int n = 1);
		repeat (n) @(posedge mclk);
		#5;
	endtask
	task cmp(string what, logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task rreg(logic [7:0] a);
		addr = a;
		reg_rd = 1;
		step;
		reg_rd = 0;
		d = rd;
		// Let an edge pass so a following call never re-raises the strobe in this step
		step;
	endtask
	task wreg(logic [7:0] a, logic [15:0] x);
		addr = a;
		wd = x;
		reg_wr = 1;
		step;
		reg_wr = 0;
		step;
	endtask
	task rst;
		reset_n = 0;
		step(8);
		reset_n = 1;
		step(2);
	endtask
	task turn(int n, logic [2:0] s);
		repeat (n) begin
			oct = oct + s;
			step;
		end
	endtask
	// Phases from electrical angle in thirds-of-a-cycle units: U [0,180), V and W lag
	function logic [2:0] three_phase_commutation_outputs(logic [13:0] a, logic [3:0] p);
		int e;
		e = (int'(a) * (int'(p) + 1)) % 16384 * 3;
		return {e < 24576, (e + 32768) % 49152 < 24576, (e + 16384) % 49152 < 24576};
	endfunction
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h03390bce));
		rst;
		// Phase pattern over random angles, both pole-pair extremes first
		for (int i = 0; i < 200; i++) begin
			ang = $urandom;
			pp = (i < 2) ? 4'(i * 15) : 4'($urandom);
			step(2);
			cmp("uvw", {13'h0000, three_phase_commutation_outputs(ang, pp)}, {13'h0000, u, v, w});
		end
		cmp("model states", 16'h0000, bad[15:0]);
		$display("test phases done");
		// Hysteresis: window trails start, exact width holds, one beyond flips
		ang = 1000;
		wid = 10;
		route = 1;
		rst;
		cmp("start angle", 16'd1000, {2'h0, qa});
		for (int i = 0; i < 8; i++) begin
			ang = 14'(tab[i][0]);
			step(2);
			cmp("filtered", 16'(tab[i][1]), {2'h0, qa});
			cmp("direction", 16'(tab[i][2]), {15'h0000, dir});
		end
		rreg(8'h22);
		cmp("readback", 16'd300, d);
		rreg(8'h24);
		cmp("status", 16'h0000, d);
		rreg(8'h40);
		cmp("unmapped", 16'h0000, d);
		// Reverse beyond the window, then a self-test restart must reload increasing
		ang = 1100;
		step(2);
		cmp("reversed", 16'h0001, {15'h0000, dir});
		self_test_done = 1;
		ang = 1105;
		step;
		self_test_done = 0;
		step;
		cmp("self test", 16'd1105, {1'b0, dir, qa});
		$display("test hysteresis done");
		// Turns: 45 degree steps to the top limit, reset, then 180 degree to bottom
		route = 0;
		rst;
		turn(100, 3'h1);
		cmp("count45", 16'h0064, {4'h0, tc});
		turn(1950, 3'h1);
		cmp("sat45", 16'h07ff, {4'h0, tc});
		wreg(8'h40, 16'h0005);
		rreg(8'h26);
		cmp("warn reg", 16'h0001, d);
		wreg(8'h1e, 16'h0005);
		rreg(8'h1e);
		cmp("control", 16'h0005, d);
		step(2);
		cmp("cleared", 16'h0000, {3'h0, warn, tc});
		tss = 0;
		turn(8, 3'h7);
		cmp("count180", 16'h0ffe, {4'h0, tc});
		turn(2052, 3'h7);
		cmp("sat180", 16'h1e00, {3'h0, warn, tc});
		$display("test turns done");
		tally_and_finish;
	end
endmodule // ach_top_tb_top
`default_nettype wire
